// >>> hdl/ppat_top.sv
// Address translator for one converter port, with Avalon-MM register slave.
// Assumes the processor issues full 32-bit port accesses on the same clock.
//
// The Avalon-MM interface to the registers was left to the implementer.
`timescale 1ns/100ps
`include "ppat_consts.svh"
module ppat_top
   import ppat_pkg::*;
(
   input  wire logic                    CLK_I,
   input  wire logic                    ARST_N_I,
   input  wire logic [`PPAT_ADDR_W-1:0] AVS_ADDRESS_I,
   input  wire logic                    AVS_READ_I,
   input  wire logic                    AVS_WRITE_I,
   input  wire logic [31:0]             AVS_WRITEDATA_I,
   input  wire logic [3:0]              AVS_BYTEENABLE_I,
   output logic      [31:0]             AVS_READDATA_O,
   output logic                         AVS_WAITREQUEST_O,
   input  wire logic                    PORT_REQ_I,
   input  wire logic [31:0]             PORT_ADDR_I,
   output logic      [31:0]             MEM_ADDR_O,
   output logic                         MEM_VALID_O
);
   // Register bus state
   ppat_bus_state_t           state_r;
   logic [7:0]                base_r [4];
   logic [`PPAT_OFF_W-1:0]    mask_r;
   logic [3:0]                mode_r;

   // Translation path
   logic [31:0]               target_base_value;
   logic [`PPAT_OFF_W-1:0]    scaled_offset;
   logic [31:0]               offset_ext;
   logic [31:0]               target_sum;

   // Read path
   logic [31:0]               rd_nxt;
   logic [31:0]               rd_base;
   logic [31:0]               rd_mask;
   logic [31:0]               rd_mode;

   // Bus decode
   logic                      req;
   logic                      hit_base;
   logic                      hit_mask;
   logic                      hit_mode;
   logic                      wr_ack;
   logic                      rd_take;
   logic [1:0]                sel;
   logic [3:0]                base_we;
   logic [3:0]                mask_we;

   // Address decode
   assign req      = AVS_READ_I | AVS_WRITE_I;
   assign sel      = AVS_ADDRESS_I[1:0];
   assign hit_base = (AVS_ADDRESS_I >= `PPAT_OFF_BASE0) && (AVS_ADDRESS_I <= `PPAT_OFF_BASE3);
   assign hit_mask = (AVS_ADDRESS_I >= `PPAT_OFF_MASK0) && (AVS_ADDRESS_I <= `PPAT_OFF_MASK3);
   assign hit_mode = (AVS_ADDRESS_I == `PPAT_OFF_MODE);

   // Write lands in the ack cycle, read data loads in the idle cycle
   // Writes need the low byte lane enabled
   assign wr_ack   = AVS_WRITE_I && (state_r == PPAT_ACK) && AVS_BYTEENABLE_I[0];
   assign rd_take  = AVS_READ_I && (state_r == PPAT_IDLE);
   assign AVS_WAITREQUEST_O = req && (state_r != PPAT_ACK);

   // One wait cycle per access
   always_ff @(posedge CLK_I or negedge ARST_N_I) begin
      if (!ARST_N_I) begin
         state_r <= PPAT_IDLE;
      end else begin
         case (state_r)
            PPAT_IDLE: begin
               if (req) begin
                  state_r <= PPAT_ACK;
               end else begin
                  state_r <= PPAT_IDLE;
               end
            end
            PPAT_ACK: begin
               state_r <= PPAT_IDLE;
            end
            default: begin
               state_r <= PPAT_IDLE;
            end
         endcase
      end
   end

   // Base bytes, bits 7:0 upward in register order
   // Index cast keeps the compare at two bits
   genvar g;
   generate
      for (g = 0; g < 4; g++) begin : g_base
         assign base_we[g] = wr_ack && hit_base && (sel == 2'(g));
         always_ff @(posedge CLK_I or negedge ARST_N_I) begin
            if (!ARST_N_I) begin
               base_r[g] <= `PPAT_BYTE_RST; // RL1
            end else if (base_we[g]) begin
               base_r[g] <= AVS_WRITEDATA_I[7:0]; // RL7
            end
         end
         assign target_base_value[8*g +: 8] = base_r[g]; // RL7
      end
   endgenerate

   // Mask byte strobes
   // Index cast keeps the compare at two bits
   genvar k;
   generate
      for (k = 0; k < 4; k++) begin : g_mask_we
         assign mask_we[k] = wr_ack && hit_mask && (sel == 2'(k));
      end
   endgenerate

   // Mask field, four bits in top byte
   always_ff @(posedge CLK_I or negedge ARST_N_I) begin
      if (!ARST_N_I) begin
         mask_r <= `PPAT_MASK_RST; // RL10
      end else begin
         if (mask_we[0]) begin
            mask_r[7:0] <= AVS_WRITEDATA_I[7:0];
         end
         if (mask_we[1]) begin
            mask_r[15:8] <= AVS_WRITEDATA_I[7:0];
         end
         if (mask_we[2]) begin
            mask_r[23:16] <= AVS_WRITEDATA_I[7:0];
         end
         if (mask_we[3]) begin
            mask_r[27:24] <= AVS_WRITEDATA_I[3:0]; // RL10
         end
      end
   end

   // Conversion mode
   always_ff @(posedge CLK_I or negedge ARST_N_I) begin
      if (!ARST_N_I) begin
         mode_r <= `PPAT_MODE_RST;
      end else if (wr_ack && hit_mode) begin
         mode_r <= AVS_WRITEDATA_I[3:0]; // RL9
      end
   end

   // Base byte read
   always_comb begin
      rd_base = `PPAT_RD_UNMAPPED;
      rd_base[7:0] = base_r[sel]; // RL7
   end

   // Mask byte read, upper nibble of top byte reads zero
   always_comb begin
      rd_mask = `PPAT_RD_UNMAPPED;
      case (sel)
         2'h0: begin
            rd_mask[7:0] = mask_r[7:0];
         end
         2'h1: begin
            rd_mask[7:0] = mask_r[15:8];
         end
         2'h2: begin
            rd_mask[7:0] = mask_r[23:16];
         end
         default: begin
            rd_mask[3:0] = mask_r[27:24]; // RL10
         end
      endcase
   end

   // Mode read
   always_comb begin
      rd_mode = `PPAT_RD_UNMAPPED;
      rd_mode[3:0] = mode_r; // RL9
   end

   // Read select, unmapped reads zero
   always_comb begin
      rd_nxt = `PPAT_RD_UNMAPPED;
      if (hit_base) begin
         rd_nxt = rd_base;
      end else if (hit_mask) begin
         rd_nxt = rd_mask;
      end else if (hit_mode) begin
         rd_nxt = rd_mode;
      end
   end

   // Read data register, stands at the edge waitrequest is low
   always_ff @(posedge CLK_I or negedge ARST_N_I) begin
      if (!ARST_N_I) begin
         AVS_READDATA_O <= `PPAT_RD_UNMAPPED;
      end else if (rd_take) begin
         AVS_READDATA_O <= rd_nxt;
      end
   end

   // Masking and scaling of the port offset
   ppat_scaler u_scaler (
      .port_off_i (PORT_ADDR_I[`PPAT_OFF_W-1:0]),
      .mask_i     (mask_r),
      .mode_i     (mode_r),
      .scaled_o   (scaled_offset)
   );

   // Zero-extended offset added to the base
   // Sum wraps at 32 bits
   assign offset_ext = {{`PPAT_TOP_NIB_W{1'b0}}, scaled_offset}; // RL6
   assign target_sum = target_base_value + offset_ext; // RL6

   // Result valid one cycle after request
   always_ff @(posedge CLK_I or negedge ARST_N_I) begin
      if (!ARST_N_I) begin
         MEM_VALID_O <= 1'b0;
      end else begin
         MEM_VALID_O <= PORT_REQ_I;
      end
   end

   // Target address, held until the next request
   always_ff @(posedge CLK_I or negedge ARST_N_I) begin
      if (!ARST_N_I) begin
         MEM_ADDR_O <= 32'h00000000;
      end else if (PORT_REQ_I) begin
         MEM_ADDR_O <= target_sum; // RL6
      end
   end

endmodule

// >>> common/ppat_consts.svh
// Constants for the pixel port address translator.
// Assumes inclusion by bare name from the package and modules.
// Functional notes
// RL1 - 32-bit writable target base, zero after reset
// RL2 - Software aligns base to selected packing
// RL3 - Masked offset: low 28 bits AND not mask
// RL4 - 8 bpp: offset shifted right two, zero filled
// RL5 - 16 bpp: offset shifted right one, zero filled
// RL6 - Target address: base plus zero-extended offset
// RL7 - Base bytes 0..3 hold bits 7:0 upward
// RL8 - Other modes: offset passes unchanged
// RL9 - Mode code 0001b 8 bpp, 0010b 16 bpp
// RL10 - Mask is 28-bit field, reset zero
// RL11 - Only 32-bit accesses, not from host
`ifndef PPAT_CONSTS_SVH
`define PPAT_CONSTS_SVH
`define PPAT_ADDR_W        8
`define PPAT_OFF_BASE0     8'hBC
`define PPAT_OFF_BASE1     8'hBD
`define PPAT_OFF_BASE2     8'hBE
`define PPAT_OFF_BASE3     8'hBF
`define PPAT_OFF_MASK0     8'hB8
`define PPAT_OFF_MASK1     8'hB9
`define PPAT_OFF_MASK2     8'hBA
`define PPAT_OFF_MASK3     8'hBB
`define PPAT_OFF_MODE      8'hB0
`define PPAT_BYTE_RST      8'h00
`define PPAT_MASK_RST      28'h0000000
`define PPAT_MODE_RST      4'h0
`define PPAT_MODE_8BPP     4'h1
`define PPAT_MODE_16BPP    4'h2
`define PPAT_OFF_W         28
`define PPAT_TOP_NIB_W     4
`define PPAT_RD_UNMAPPED   32'h00000000
`endif

// >>> common/ppat_pkg.sv
// Types for the pixel port address translator.
// Assumes the consts header is on the include path.
`include "ppat_consts.svh"
package ppat_pkg;
   typedef enum logic [1:0] {
      PPAT_IDLE = 2'b01,
      PPAT_ACK  = 2'b10
   } ppat_bus_state_t;
   typedef logic [`PPAT_OFF_W-1:0] ppat_offset_t;
endpackage

// >>> hdl/ppat_scaler.sv
// Offset masking and scaling for the port address.
// Assumes mode and mask come from registers on the same clock.
`timescale 1ns/100ps
`include "ppat_consts.svh"
module ppat_scaler
   import ppat_pkg::*;
(
   input  wire logic [`PPAT_OFF_W-1:0] port_off_i,
   input  wire logic [`PPAT_OFF_W-1:0] mask_i,
   input  wire logic [3:0]             mode_i,
   output logic      [`PPAT_OFF_W-1:0] scaled_o
);
   ppat_offset_t masked_offset;
   assign masked_offset = port_off_i & ~mask_i; // RL3
   always_comb begin
      case (mode_i) // RL9
         `PPAT_MODE_8BPP:  scaled_o = {2'b00, masked_offset[`PPAT_OFF_W-1:2]}; // RL4
         `PPAT_MODE_16BPP: scaled_o = {1'b0, masked_offset[`PPAT_OFF_W-1:1]}; // RL5
         default:          scaled_o = masked_offset; // RL8
      endcase
   end
endmodule

// >>> testbench/ppat_top_monitor.sv
// Port checks for the translator top.
// Assumes it is bound onto ppat_top.
`timescale 1ns/100ps
module ppat_top_monitor (
   input wire logic        CLK_I,
   input wire logic        ARST_N_I,
   input wire logic [7:0]  AVS_ADDRESS_I,
   input wire logic        AVS_READ_I,
   input wire logic        AVS_WRITE_I,
   input wire logic [31:0] AVS_READDATA_O,
   input wire logic        AVS_WAITREQUEST_O,
   input wire logic        PORT_REQ_I,
   input wire logic [31:0] MEM_ADDR_O,
   input wire logic        MEM_VALID_O
);
   default clocking @(posedge CLK_I); endclocking
   default disable iff (!ARST_N_I);
   wire rq = AVS_READ_I | AVS_WRITE_I;
   wire rk = AVS_READ_I & !AVS_WAITREQUEST_O;
   a_valid_delay: assert property (PORT_REQ_I |=> MEM_VALID_O) else $error("valid");
   a_valid_single: assert property (!PORT_REQ_I |=> !MEM_VALID_O) else $error("vld");
   a_addr_hold: assert property (!PORT_REQ_I |=> $stable(MEM_ADDR_O)) else $error("adr");
   a_reset_clear: assert property ($rose(ARST_N_I) |-> MEM_ADDR_O == 0) else $error("rst");
   a_wait_once: assert property (rq && AVS_WAITREQUEST_O |=> !AVS_WAITREQUEST_O)
      else $error("wait");
   a_idle_nowait: assert property (!rq |-> !AVS_WAITREQUEST_O) else $error("idle");
   a_byte_only: assert property (rk |-> AVS_READDATA_O[31:8] == 0) else $error("hi");
   a_unmapped_zero: assert property (rk && AVS_ADDRESS_I < 8'hB0 |-> AVS_READDATA_O == 0)
      else $error("unmapped");
   a_mask_top: assert property (rk && AVS_ADDRESS_I == 8'hBB |-> AVS_READDATA_O[7:4] == 0)
      else $error("mask");
   cover property (MEM_VALID_O && MEM_ADDR_O != 0);
   cover property (AVS_WRITE_I && !AVS_WAITREQUEST_O);
   cover property (rk && AVS_ADDRESS_I == 8'hBB);
endmodule
bind ppat_top ppat_top_monitor ppat_top_monitor_i (.CLK_I, .ARST_N_I, .AVS_ADDRESS_I,
   .AVS_READ_I, .AVS_WRITE_I, .AVS_READDATA_O, .AVS_WAITREQUEST_O, .PORT_REQ_I,
   .MEM_ADDR_O, .MEM_VALID_O);

// >>> testbench/ppat_cpu_model.sv
// Processor side issuing port accesses.
// Assumes the shared system clock.
`timescale 1ns/100ps
module ppat_cpu_model (
   input  wire logic        clk_i,
   output logic             req_o,
   output logic [31:0]      addr_o
);
   initial begin
      req_o  = 1'b0;
      addr_o = 32'h0;
   end
   task automatic issue(input logic [31:0] a);
      @(posedge clk_i);
      req_o  <= 1'b1;
      addr_o <= a;
      @(posedge clk_i);
      req_o  <= 1'b0;
      addr_o <= ~a;
   endtask
endmodule

// >>> testbench/testbench.sv
// Bench for the translator top.
// Assumes the monitor binds itself.
`timescale 1ns/100ps
module testbench;
   logic        CLK_I = 0, ARST_N_I = 0, rd = 0, wr = 0, wq, vld, req;
   logic [7:0]  adr = 0;
   logic [31:0] wd = 0, q, rdat, mem, pa, b, m;
   int          err_count = 0, num_checks = 0, cyc = 0;
   ppat_cpu_model ppat_cpu_model_i (.clk_i(CLK_I), .req_o(req), .addr_o(pa));
   ppat_top ppat_top_i (.CLK_I, .ARST_N_I, .AVS_ADDRESS_I(adr), .AVS_READ_I(rd),
      .AVS_WRITE_I(wr), .AVS_WRITEDATA_I(wd), .AVS_BYTEENABLE_I(4'hF),
      .AVS_READDATA_O(rdat), .AVS_WAITREQUEST_O(wq), .PORT_REQ_I(req),
      .PORT_ADDR_I(pa), .MEM_ADDR_O(mem), .MEM_VALID_O(vld));
   always #5 CLK_I = ~CLK_I;
   always @(posedge CLK_I) begin
      cyc++;
      if (cyc > 3000) begin
         err_count++;
         wrap_up();
      end
   end
   task automatic chk(input string n, input logic [31:0] s, e);
      num_checks++;
      if (s !== e) begin
         err_count++;
         $display("MISMATCH %s exp %h seen %h", n, e, s);
      end
   endtask
   task automatic bus(input logic w, input logic [7:0] a, input logic [31:0] d);
      @(posedge CLK_I);
      adr <= a;
      wd <= d;
      wr <= w;
      rd <= !w;
      do @(posedge CLK_I); while (wq !== 1'b0);
      q = rdat;
      rd <= 1'b0;
      wr <= 1'b0;
   endtask
   function automatic logic [31:0] scale(logic [31:0] a, int md);
      logic [27:0] o;
      o = a[27:0] & ~m[27:0];
      return md == 1 ? o >> 2 : md == 2 ? o >> 1 : o;
   endfunction
   task automatic wrap_up;
      $display("checks %0d errors %0d", num_checks, err_count);
      if (err_count == 0 && num_checks > 0) $display("Run complete: PASS");
      else $display("Run complete: FAIL");
      $finish;
   endtask
   initial begin
      void'($urandom(32'hAA4E));
      repeat (5) @(posedge CLK_I);
      ARST_N_I <= 1'b1;
      b = $urandom & 32'hFFFFFFFC;
      m = {8'h0F, $urandom} & 32'h0F0F0F0F;
      for (int i = 0; i < 4; i++) begin
         bus(0, 8'hBC + i, 0);
         chk("base rst", q, 0);
         bus(1, 8'hBC + i, b[8*i+:8]);
         bus(1, 8'hB8 + i, m[8*i+:8] | 8'hF0);
      end
      bus(0, 8'h00, 0);
      chk("unmapped", q, 0);
      bus(0, 8'hBB, 0);
      chk("mask top", q, {28'h0, m[27:24]});
      for (int i = 0; i < 4; i++) begin
         bus(0, 8'hBC + i, 0);
         chk("base", q, b[8*i+:8]);
      end
      m = m | 32'h00F0F0F0;
      for (int md = 0; md < 16; md++) begin
         bus(1, 8'hB0, md);
         ppat_cpu_model_i.issue($urandom);
         @(negedge CLK_I);
         chk("valid", vld, 1);
         chk("target", mem, b + scale(~pa, md));
      end
      wrap_up();
   end
endmodule
